// ### ffc_defs.vh
// Purpose: constants for the amplifier control word decoder
// Assumes: 16-bit control word shifted in msb first over a 3-wire port
// Notes:   field positions, codes and reset value of the control word
//
// Function
// [R1] gain codes 000 to 110: feedback switch b follows the ext cap bit.
// [R2] gain code 111 holds feedback switch b closed regardless of cap bit.
// [R3] ext cap path enable is control bit 10; 1 means capacitor fitted.
// [R4] host clears the ext cap bit when no filter capacitor is fitted.
// [R5] bit 11 routes the current source: 0 positive pin, 1 negative pin.
// [R6] bits 14:12 pick source level; 110 powered but off; 111 forbidden.
// [R7] host may leave the source powered but disconnected between tests.
// [R8] host writes 0082 or 00C2 for common-mode and rail short checks.
// [R9] host writes 5082 or 58C2 for open input checks at 100 uA.
// [R10] host writes 5000 for the shorted inputs check.
// [R11] host compares readings after 5082 and 58C2 to find a degraded line.
// [R12] host may run the test words in sequence and compare readings.
// [R13] gain code sits in bits 2:0; 111 means external resistor gain.
// [R14] bandwidth trim field sits in bits 5:3.
// [R15] route select and sign invert sit in bits 8:6.
// [R16] switch and source controls follow the stored word right after a write.
`ifndef FFC_DEFS_VH
`define FFC_DEFS_VH

// ============================================================
// word layout
`define FFC_WORD_W        16
`define FFC_WORD_RST      16'h0000
`define FFC_CNT_W         5
`define FFC_CNT_FULL      5'h10
`define FFC_CNT_OVER      5'h11
`define FFC_GAIN_HI       2
`define FFC_GAIN_LO       0
`define FFC_BW_HI         5
`define FFC_BW_LO         3
`define FFC_ROUTE_HI      7
`define FFC_ROUTE_LO      6
`define FFC_SIGN_BIT      8
`define FFC_SHDN_BIT      9
`define FFC_CAP_BIT       10
`define FFC_PIN_BIT       11
`define FFC_AMPS_HI       14
`define FFC_AMPS_LO       12

// ============================================================
// codes
`define FFC_GAIN_EXT      3'h7
`define FFC_AMPS_OFF      3'h0
`define FFC_AMPS_10N      3'h1
`define FFC_AMPS_100N     3'h2
`define FFC_AMPS_1U       3'h3
`define FFC_AMPS_10U      3'h4
`define FFC_AMPS_100U     3'h5
`define FFC_AMPS_IDLE     3'h6
`define FFC_AMPS_BAD      3'h7
`define FFC_LVL_W         5

`endif

// ### ffc_ctrl_word.v
// Purpose: serial control word receiver and switch/current source decode
// Assumes: host drives select low, clocks 16 bits msb first on rising clk
// Notes:   all pins are synchronised to mclk; outputs lag the word by one
//          clock; frames that do not hold exactly 16 bits are discarded
//          route select sits in bits 7:6, sign invert in bit 8
//          a stored level code 111 keeps the source off and raises a flag
`timescale 1ns/10ps
`include "ffc_defs.vh"

module ffc_ctrl_word #(
  parameter WORD_W = `FFC_WORD_W
) (
  input  wire              mclk,
  input  wire              sys_rst,
  input  wire              ser_clk_pin,
  input  wire              ser_sel_n_pin,
  input  wire              ser_data_pin,
  output reg  [WORD_W-1:0] ctl_word,
  output reg  [2:0]        gain_code,
  output reg  [2:0]        bandwidth_trim,
  output reg  [1:0]        input_route_select,
  output reg               sign_invert,
  output reg               shutdown_en,
  output reg               ext_cap_path_enable,
  output reg               source_terminal_select,
  output reg  [2:0]        inject_amps_level,
  output reg               feedback_switch_a,
  output reg               feedback_switch_b,
  output reg               src_to_pos,
  output reg               src_to_neg,
  output reg               src_powered,
  output reg  [4:0]        src_level_onehot,
  output reg               inject_code_bad,
  output reg               write_done
);

  // ==========================================================
  // pin synchronisers
  reg  [1:0]              clk_sync_r;
  reg  [1:0]              sel_sync_r;
  reg  [1:0]              dat_sync_r;
  reg                     clk_last_r;
  reg                     sel_last_r;
  reg  [WORD_W-1:0]       shift_r;
  reg  [`FFC_CNT_W-1:0]   cnt_r;
  reg  [WORD_W-1:0]       word_r;
  reg                     load_r;
  wire                    clk_rise;
  wire                    sel_rise;
  wire                    sel_act;
  reg  [WORD_W-1:0]       shift_nxt;
  reg  [`FFC_CNT_W-1:0]   cnt_nxt;
  reg  [WORD_W-1:0]       word_nxt;
  reg                     load_nxt;

  always @(posedge mclk) begin
    if (sys_rst) begin
      clk_sync_r <= 2'h0;
      sel_sync_r <= 2'h3;
      dat_sync_r <= 2'h0;
      clk_last_r <= 1'b0;
      sel_last_r <= 1'b1;
    end else begin
      clk_sync_r <= {clk_sync_r[0], ser_clk_pin};
      sel_sync_r <= {sel_sync_r[0], ser_sel_n_pin};
      dat_sync_r <= {dat_sync_r[0], ser_data_pin};
      clk_last_r <= clk_sync_r[1];
      sel_last_r <= sel_sync_r[1];
    end
  end

  assign clk_rise = clk_sync_r[1] & ~clk_last_r;
  assign sel_rise = sel_sync_r[1] & ~sel_last_r;
  assign sel_act  = ~sel_sync_r[1];

  // ==========================================================
  // frame bit counter and shift register
  always @* begin
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    word_nxt  = word_r;
    load_nxt  = 1'b0;
    if (sel_rise) begin
      if (cnt_r == `FFC_CNT_FULL) begin
        word_nxt = shift_r; // R16
        load_nxt = 1'b1;
      end
      cnt_nxt = {`FFC_CNT_W{1'b0}};
    end else if (sel_act && clk_rise) begin
      shift_nxt = {shift_r[WORD_W-2:0], dat_sync_r[1]};
      if (cnt_r != `FFC_CNT_OVER)
        cnt_nxt = cnt_r + 1'b1;
    end else if (!sel_act) begin
      cnt_nxt = {`FFC_CNT_W{1'b0}};
    end
  end

  // ==========================================================
  // word store registers
  always @(posedge mclk) begin
    if (sys_rst) begin
      shift_r <= `FFC_WORD_RST;
      cnt_r   <= {`FFC_CNT_W{1'b0}};
      word_r  <= `FFC_WORD_RST;
      load_r  <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      word_r  <= word_nxt;
      load_r  <= load_nxt;
    end
  end

  // ==========================================================
  // field decode
  function [4:0] lvl_decode;
    input [2:0] code;
    begin
      case (code)
        `FFC_AMPS_OFF:  lvl_decode = 5'h00;
        `FFC_AMPS_10N:  lvl_decode = 5'h01;
        `FFC_AMPS_100N: lvl_decode = 5'h02;
        `FFC_AMPS_1U:   lvl_decode = 5'h04;
        `FFC_AMPS_10U:  lvl_decode = 5'h08;
        `FFC_AMPS_100U: lvl_decode = 5'h10;
        `FFC_AMPS_IDLE: lvl_decode = 5'h00;
        `FFC_AMPS_BAD:  lvl_decode = 5'h00;
        default:       lvl_decode = 5'h00;
      endcase
    end
  endfunction

  wire [2:0] gain_w = word_r[`FFC_GAIN_HI:`FFC_GAIN_LO]; // R13
  wire [2:0] amps_w = word_r[`FFC_AMPS_HI:`FFC_AMPS_LO]; // R6
  wire       cap_w  = word_r[`FFC_CAP_BIT];              // R3
  wire       pin_w  = word_r[`FFC_PIN_BIT];              // R5
  wire [4:0] lvl_w  = lvl_decode(amps_w);
  wire       on_w   = (lvl_w != 5'h00);

  // ==========================================================
  // output next values
  reg  [WORD_W-1:0]       ctl_word_nxt;
  reg  [2:0]              gain_code_nxt;
  reg  [2:0]              bandwidth_trim_nxt;
  reg  [1:0]              input_route_select_nxt;
  reg                     sign_invert_nxt;
  reg                     shutdown_en_nxt;
  reg                     ext_cap_path_enable_nxt;
  reg                     source_terminal_select_nxt;
  reg  [2:0]              inject_amps_level_nxt;
  reg                     feedback_switch_a_nxt;
  reg                     feedback_switch_b_nxt;
  reg                     src_to_pos_nxt;
  reg                     src_to_neg_nxt;
  reg                     src_powered_nxt;
  reg  [4:0]              src_level_onehot_nxt;
  reg                     inject_code_bad_nxt;
  reg                     write_done_nxt;

  always @* begin
    ctl_word_nxt               = word_r;
    gain_code_nxt              = gain_w; // R13
    bandwidth_trim_nxt         = word_r[`FFC_BW_HI:`FFC_BW_LO]; // R14
    input_route_select_nxt     = word_r[`FFC_ROUTE_HI:`FFC_ROUTE_LO]; // R15
    sign_invert_nxt            = word_r[`FFC_SIGN_BIT]; // R15
    shutdown_en_nxt            = word_r[`FFC_SHDN_BIT];
    ext_cap_path_enable_nxt    = cap_w; // R3
    source_terminal_select_nxt = pin_w; // R5
    inject_amps_level_nxt      = amps_w; // R6
    feedback_switch_a_nxt      = (gain_w != `FFC_GAIN_EXT);
    if (gain_w == `FFC_GAIN_EXT)
      feedback_switch_b_nxt = 1'b1; // R2
    else
      feedback_switch_b_nxt = cap_w; // R1
    src_to_pos_nxt             = on_w & ~pin_w; // R5
    src_to_neg_nxt             = on_w & pin_w; // R5
    src_powered_nxt            = on_w | (amps_w == `FFC_AMPS_IDLE); // R6
    src_level_onehot_nxt       = lvl_w; // R6
    inject_code_bad_nxt        = (amps_w == `FFC_AMPS_BAD); // R6
    write_done_nxt             = load_r; // R16
  end

  // ==========================================================
  // output registers
  always @(posedge mclk) begin
    if (sys_rst) begin
      ctl_word               <= `FFC_WORD_RST;
      gain_code              <= 3'h0;
      bandwidth_trim         <= 3'h0;
      input_route_select     <= 2'h0;
      sign_invert            <= 1'b0;
      shutdown_en            <= 1'b0;
      ext_cap_path_enable    <= 1'b0;
      source_terminal_select <= 1'b0;
      inject_amps_level      <= 3'h0;
      feedback_switch_a      <= 1'b1;
      feedback_switch_b      <= 1'b0;
      src_to_pos             <= 1'b0;
      src_to_neg             <= 1'b0;
      src_powered            <= 1'b0;
      src_level_onehot       <= 5'h00;
      inject_code_bad        <= 1'b0;
      write_done             <= 1'b0;
    end else begin
      ctl_word               <= ctl_word_nxt;
      gain_code              <= gain_code_nxt;
      bandwidth_trim         <= bandwidth_trim_nxt;
      input_route_select     <= input_route_select_nxt;
      sign_invert            <= sign_invert_nxt;
      shutdown_en            <= shutdown_en_nxt;
      ext_cap_path_enable    <= ext_cap_path_enable_nxt;
      source_terminal_select <= source_terminal_select_nxt;
      inject_amps_level      <= inject_amps_level_nxt;
      feedback_switch_a      <= feedback_switch_a_nxt;
      feedback_switch_b      <= feedback_switch_b_nxt;
      src_to_pos             <= src_to_pos_nxt;
      src_to_neg             <= src_to_neg_nxt;
      src_powered            <= src_powered_nxt;
      src_level_onehot       <= src_level_onehot_nxt;
      inject_code_bad        <= inject_code_bad_nxt;
      write_done             <= write_done_nxt;
    end
  end

endmodule

// ### ffc_checker.sv
// Purpose: port checks for ffc_ctrl_word
// Assumes: fields settle together with write_done
// Notes:   bound in the bench top file
`timescale 1ns/10ps
module ffc_checker #(parameter WORD_W = 16) (
  input wire              mclk,
  input wire              sys_rst,
  input wire [WORD_W-1:0] ctl_word,
  input wire [2:0]        gain_code,
  input wire              ext_cap_path_enable,
  input wire              source_terminal_select,
  input wire [2:0]        inject_amps_level,
  input wire              feedback_switch_b,
  input wire              src_to_pos,
  input wire              src_to_neg,
  input wire              src_powered,
  input wire              inject_code_bad,
  input wire              write_done
);
  // ====
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire [2:0] lvl = inject_amps_level;
  wire       on  = lvl != 3'h0 && lvl < 3'h6;
  sequence s_pulse; write_done ##1 !write_done; endsequence
  a_switch_cap: assert property (gain_code != 3'h7 |->
    feedback_switch_b == ext_cap_path_enable) else $error("switch b");
  a_switch_ext: assert property (gain_code == 3'h7 |->
    feedback_switch_b) else $error("switch ext");
  a_src_route: assert property (src_to_neg == (on & source_terminal_select)
    && src_to_pos == (on & !source_terminal_select)) else $error("route");
  a_src_power: assert property (src_powered ==
    (lvl != 3'h0 && lvl != 3'h7)) else $error("power");
  a_code_bad: assert property (inject_code_bad == (lvl == 3'h7))
    else $error("bad code");
  a_word_fields: assert property (write_done |->
    gain_code == ctl_word[2:0] && ext_cap_path_enable == ctl_word[10])
    else $error("fields");
  a_done_pulse: assert property (write_done |-> s_pulse)
    else $error("pulse");
  a_quiet_fields: assert property ($changed(feedback_switch_b) ||
    $changed(src_powered) |-> write_done) else $error("change");
endmodule

// ### ffc_host_model.sv
// Purpose: host framing control words on the serial port
// Assumes: mode 0, msb first, each phase four mclk
// Notes:   clock idles low; data idles inverted
`timescale 1ns/10ps
module ffc_host_model (
  input  wire mclk,
  output reg  ser_clk_pin,
  output reg  ser_sel_n_pin,
  output reg  ser_data_pin
);
  initial begin
    ser_clk_pin = 1'b0;
    ser_sel_n_pin = 1'b1;
    ser_data_pin = 1'b0;
  end
  task automatic send(input [15:0] w, input int n);
    @(negedge mclk);
    ser_sel_n_pin = 1'b0;
    for (int i = 0; i < n; i++) begin
      ser_data_pin = i < 16 ? w[15 - i] : 1'b1;
      repeat (4) @(negedge mclk);
      ser_clk_pin = 1'b1;
      repeat (4) @(negedge mclk);
      ser_clk_pin = 1'b0;
      repeat (4) @(negedge mclk);
    end
    ser_sel_n_pin = 1'b1;
    ser_data_pin = ~ser_data_pin;
  endtask
endmodule

// ### test_filter_and_fault_current_config.sv
// Purpose: self-checking bench for ffc_ctrl_word
// Assumes: host model drives at mclk falling edges
// Notes:   one task per scenario
`timescale 1ns/10ps
module test_filter_and_fault_current_config;
  reg         mclk, sys_rst;
  wire        ser_clk_pin, ser_sel_n_pin, ser_data_pin, shutdown_en;
  wire [15:0] ctl_word;
  wire [2:0]  gain_code, bandwidth_trim, inject_amps_level;
  wire [1:0]  input_route_select;
  wire [4:0]  src_level_onehot;
  wire        sign_invert, ext_cap_path_enable, source_terminal_select;
  wire        feedback_switch_a, feedback_switch_b, src_to_pos, src_to_neg;
  wire        src_powered, inject_code_bad, write_done;
  int         fail_count = 0, n_tests = 0;
  ffc_ctrl_word uut (.mclk, .sys_rst, .ser_clk_pin, .ser_sel_n_pin,
    .ser_data_pin, .ctl_word, .gain_code, .bandwidth_trim,
    .input_route_select, .sign_invert, .shutdown_en, .ext_cap_path_enable,
    .source_terminal_select, .inject_amps_level, .feedback_switch_a,
    .feedback_switch_b, .src_to_pos, .src_to_neg, .src_powered,
    .src_level_onehot, .inject_code_bad, .write_done);
  ffc_host_model host (.mclk, .ser_clk_pin, .ser_sel_n_pin, .ser_data_pin);
  task automatic chk(input [15:0] got, input [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input [15:0] w, input int n, input bit done);
    bit seen = 0;
    host.send(w, n);
    repeat (10) begin
      @(negedge mclk);
      seen |= write_done === 1'b1;
    end
    chk(seen, done);
    if (done && !seen) close_out;
  endtask
  task automatic ex(input [15:0] w);
    bit on = w[14:12] != 3'h0 && w[14:12] < 3'h6;
    chk(ctl_word, w);
    chk({sign_invert, input_route_select, bandwidth_trim}, w[8:3]);
    chk({shutdown_en, gain_code}, {w[9], w[2:0]});
    chk({source_terminal_select, ext_cap_path_enable}, w[11:10]);
    chk(inject_amps_level, w[14:12]);
    chk(feedback_switch_a, w[2:0] != 3'h7);
    chk(feedback_switch_b, w[2:0] == 3'h7 || w[10]);
    chk({src_to_neg, src_to_pos}, {on & w[11], on & ~w[11]});
    chk(src_level_onehot, on ? 5'h01 << (w[14:12] - 3'h1) : 5'h00);
    chk(src_powered, on || w[14:12] == 3'h6);
    chk(inject_code_bad, w[14:12] == 3'h7);
  endtask
  task automatic t_switch;
    wr(16'h0406, 16, 1);
    ex(16'h0406);
    wr(16'h0007, 16, 1);
    ex(16'h0007);
  endtask
  task automatic t_levels;
    for (int c = 0; c < 16; c++) begin
      wr({1'b0, c[2:0], c[3], 11'h405}, 16, 1);
      ex({1'b0, c[2:0], c[3], 11'h405});
    end
  endtask
  task automatic t_faults;
    logic [15:0] tw [5] = '{16'h0082, 16'h00C2, 16'h5082, 16'h58C2, 16'h5000};
    logic [1:0]  rt [5] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h0};
    foreach (tw[i]) begin
      wr(tw[i], 16, 1);
      ex(tw[i]);
      chk({sign_invert, input_route_select}, {1'b0, rt[i]});
    end
  endtask
  task automatic t_refuse;
    wr(16'h7FFF, 15, 0);
    wr(16'h7FFF, 17, 0);
    ex(16'h5000);
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    sys_rst = 1'b1;
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    ex(16'h0000);
    t_switch;
    t_faults;
    t_refuse;
    t_levels;
    close_out;
  end
endmodule
bind ffc_ctrl_word ffc_checker #(.WORD_W(WORD_W)) u_chk (.mclk, .sys_rst,
  .ctl_word, .gain_code, .ext_cap_path_enable, .source_terminal_select,
  .inject_amps_level, .feedback_switch_b, .src_to_pos, .src_to_neg,
  .src_powered, .inject_code_bad, .write_done);
